// ### hw/uec_endpoint_control.sv
/*
 Endpoint control of a full/low-speed USB function with an AXI4-Lite register slave.
 Assumes the serial engine presents tokens and transmit ends on sys_clk, one-cycle valid.
*/
// Our own choice: the AXI4-Lite register port.
// What this block does
// - wakeup bit set drives resume; clear stops
// - two-bit select code picks endpoint 0..3
// - indexed registers reach the selected endpoint's copy
// - rx stall: OUT gets STALL, NAK if setup
// - rx stall spares SETUP; SETUP clears it
// - tx stall: IN STALL/NAK; SETUP clears it
// - only control endpoints accept SETUP
// - silent flag: IN/OUT get no handshake
// - closed rx gate: OUT dropped and NAKed
// - SETUP stored despite closed rx gate
// - rx disabled: no answer to OUT/SETUP
// - rx enable outranks gate and stall
// - tx not allowed: IN gets NAK
// - tx disabled: no answer to IN
// - reset config ep0 00100101, others zero
`timescale 1ns/10ps
`default_nettype none
`include "uec_map.svh"
module uec_endpoint_control
    import uec_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire uec_token_t  tok,
    input  wire uec_txend_t  tx_end,
    output var  uec_reply_t  reply,
    output var  logic        resume_drive
);
    logic [7:0] cfg_reg [4];
    logic [7:0] txres_reg [4];
    logic [3:0] setup_reg;
    logic [1:0] sel_reg;
    logic       wake_reg;
    logic       aw_got_reg;
    logic       w_got_reg;
    logic [7:0] aw_idx_reg;
    logic [7:0] wdata_reg;
    logic       wstrb_reg;
    logic       aw_fire;
    logic       w_fire;
    logic       ar_fire;
    logic       do_write;
    logic       aw_got_next;
    logic       w_got_next;
    logic       rvalid_next;
    logic       wr_lane;
    logic       setup_ok;
    uec_reply_t reply_next;

    // ============================================================
    // decoding shared by write and read paths
    function automatic logic reg_hit(input logic [7:0] idx);
        reg_hit = (idx == `UEC_IDX_WAKE) || (idx == `UEC_IDX_SEL) ||
                  (idx == `UEC_IDX_CFG) || (idx == `UEC_IDX_TXRES) ||
                  (idx == `UEC_IDX_RXFLG);
    endfunction

    // reserved bits read as zero
    function automatic logic [7:0] reg_read(input logic [7:0] idx);
        unique case (idx)
            `UEC_IDX_WAKE:  reg_read = {7'h00, wake_reg};
            `UEC_IDX_SEL:   reg_read = {6'h00, sel_reg};
            `UEC_IDX_CFG:   reg_read = cfg_reg[sel_reg];
            `UEC_IDX_TXRES: reg_read = txres_reg[sel_reg];
            `UEC_IDX_RXFLG: reg_read = 8'(setup_reg[sel_reg]) << `UEC_RXFLG_SETUP;
            default:        reg_read = `UEC_BYTE_ZERO;
        endcase
    endfunction

    // ============================================================
    // token answer: enable first, then silence, stall, gate
    function automatic uec_reply_t decide(input uec_token_t t, input logic [7:0] c,
                                          input logic s);
        decide = '{valid: t.valid, hs: UEC_HS_NONE, store: 1'b0, ep: t.ep};
        unique case (t.pid)
            UEC_PID_OUT: begin
                if (!c[`UEC_CFG_RXON] || c[`UEC_CFG_SILENT]) begin
                    decide.hs = UEC_HS_NONE;
                end else if (c[`UEC_CFG_RX_STALL_REQUEST]) begin
                    decide.hs = s ? UEC_HS_NAK : UEC_HS_STALL;
                end else if (!c[`UEC_CFG_RXGATE]) begin
                    decide.hs = UEC_HS_NAK;
                end else begin
                    decide.hs = UEC_HS_ACK;
                    decide.store = 1'b1;
                end
            end
            UEC_PID_SETUP: begin
                // stall and gate are deliberately not looked at here
                if (c[`UEC_CFG_RXON] && c[`UEC_CFG_CTL]) begin
                    decide.hs = UEC_HS_ACK;
                    decide.store = 1'b1;
                end
            end
            UEC_PID_IN: begin
                if (!c[`UEC_CFG_TXON] || c[`UEC_CFG_SILENT]) begin
                    decide.hs = UEC_HS_NONE;
                end else if (c[`UEC_CFG_TX_STALL_REQUEST]) begin
                    decide.hs = s ? UEC_HS_NAK : UEC_HS_STALL;
                end else if (!c[`UEC_CFG_TXALLOW]) begin
                    decide.hs = UEC_HS_NAK;
                end else begin
                    decide.hs = UEC_HS_DATA;
                end
            end
            default: decide.valid = 1'b0;
        endcase
    endfunction

    // ============================================================
    // bus handshakes
    assign aw_fire     = s_axi_awvalid && s_axi_awready;
    assign w_fire      = s_axi_wvalid && s_axi_wready;
    assign ar_fire     = s_axi_arvalid && s_axi_arready;
    assign do_write    = aw_got_reg && w_got_reg && !s_axi_bvalid;
    assign aw_got_next = !do_write && (aw_fire || aw_got_reg);
    assign w_got_next  = !do_write && (w_fire || w_got_reg);
    assign rvalid_next = ar_fire || (s_axi_rvalid && !s_axi_rready);
    assign wr_lane     = do_write && wstrb_reg;
    assign reply_next  = decide(tok, cfg_reg[tok.ep], setup_reg[tok.ep]);
    assign setup_ok    = reply_next.valid && (tok.pid == UEC_PID_SETUP) &&
                         (reply_next.hs == UEC_HS_ACK);

    // write address and data are captured in either order
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            aw_idx_reg    <= `UEC_BYTE_ZERO;
            wdata_reg     <= `UEC_BYTE_ZERO;
            wstrb_reg     <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            aw_got_reg    <= aw_got_next;
            w_got_reg     <= w_got_next;
            s_axi_awready <= !aw_got_next;
            s_axi_wready  <= !w_got_next;
            if (aw_fire) begin
                aw_idx_reg <= s_axi_awaddr[9:2];
            end
            if (w_fire) begin
                wdata_reg <= s_axi_wdata[7:0];
                wstrb_reg <= s_axi_wstrb[0];
            end
        end
    end

    // write response, unmapped index answers slverr
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `UEC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= reg_hit(aw_idx_reg) ? `UEC_RESP_OKAY : `UEC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read channel, data taken in the address cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `UEC_RESP_OKAY;
        end else begin
            s_axi_arready <= !rvalid_next;
            s_axi_rvalid  <= rvalid_next;
            if (ar_fire) begin
                s_axi_rdata <= {24'h00_0000, reg_read(s_axi_araddr[9:2])};
                s_axi_rresp <= reg_hit(s_axi_araddr[9:2]) ? `UEC_RESP_OKAY
                                                           : `UEC_RESP_SLVERR;
            end
        end
    end

    // ============================================================
    // wakeup and selection; reserved bits are simply not stored
    // resume lasts exactly as long as firmware holds the bit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wake_reg     <= 1'b0;
            sel_reg      <= 2'h0;
            resume_drive <= 1'b0;
        end else begin
            if (wr_lane && aw_idx_reg == `UEC_IDX_WAKE) begin
                wake_reg <= wdata_reg[`UEC_WAKE_BIT];
            end
            if (wr_lane && aw_idx_reg == `UEC_IDX_SEL) begin
                sel_reg <= wdata_reg[1:0];
            end
            resume_drive <= wake_reg;
        end
    end

    // ============================================================
    // per-endpoint banks
    for (genvar e = 0; e < 4; e++) begin : g_ep
        logic fw_hit;
        logic tok_hit;
        logic end_hit;
        assign fw_hit  = wr_lane && (sel_reg == 2'(e));
        assign tok_hit = reply_next.valid && (tok.ep == 2'(e));
        assign end_hit = tx_end.valid && (tx_end.ep == 2'(e));

        // hardware clearing of stalls on setup beats a firmware write
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                cfg_reg[e] <= (e == 0) ? `UEC_CFG_RST_EP0 : `UEC_CFG_RST_EPN;
            end else begin
                if (fw_hit && aw_idx_reg == `UEC_IDX_CFG) begin
                    cfg_reg[e] <= wdata_reg;
                end
                if (tok_hit && setup_ok) begin
                    cfg_reg[e][`UEC_CFG_RX_STALL_REQUEST] <= 1'b0;
                    cfg_reg[e][`UEC_CFG_TX_STALL_REQUEST] <= 1'b0;
                end
            end
        end

        // setup flag: hardware set wins over firmware clear
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                setup_reg[e] <= 1'b0;
            end else if (tok_hit && setup_ok) begin
                setup_reg[e] <= 1'b1;
            end else if (fw_hit && aw_idx_reg == `UEC_IDX_RXFLG &&
                         !wdata_reg[`UEC_RXFLG_SETUP]) begin
                setup_reg[e] <= 1'b0;
            end
        end

        // transmit result; sequence bit is clear-only for firmware
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                txres_reg[e] <= `UEC_BYTE_ZERO;
            end else begin
                if (fw_hit && aw_idx_reg == `UEC_IDX_TXRES &&
                    !wdata_reg[`UEC_TXRES_SEQ]) begin
                    txres_reg[e][`UEC_TXRES_SEQ] <= 1'b0;
                end
                if (tok_hit && tok.pid == UEC_PID_IN && reply_next.hs != UEC_HS_NONE) begin
                    txres_reg[e][`UEC_TXRES_VOID] <= (reply_next.hs != UEC_HS_DATA);
                end
                if (end_hit) begin
                    txres_reg[e][`UEC_TXRES_ACK] <= tx_end.acked;
                    txres_reg[e][`UEC_TXRES_ERR] <= !tx_end.acked;
                end
                if ((end_hit && tx_end.acked) != (tok_hit && setup_ok)) begin
                    txres_reg[e][`UEC_TXRES_SEQ] <= !txres_reg[e][`UEC_TXRES_SEQ];
                end
            end
        end
    end

    // answer goes out one cycle after the token
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reply <= '{valid: 1'b0, hs: UEC_HS_NONE, store: 1'b0, ep: 2'h0};
        end else begin
            reply <= reply_next;
        end
    end

    // ============================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_tok_out;
        tok.valid && tok.pid == UEC_PID_OUT;
    endsequence
    sequence s_tok_in;
        tok.valid && tok.pid == UEC_PID_IN;
    endsequence
    sequence s_tok_setup;
        tok.valid && tok.pid == UEC_PID_SETUP;
    endsequence

    a_resume_follows: assert property (resume_drive == $past(wake_reg))
        else $error("resume not driven");
    a_sel_reaches: assert property (ar_fire && s_axi_araddr[9:2] == `UEC_IDX_CFG
        |=> s_axi_rdata[7:0] == $past(cfg_reg[sel_reg])) else $error("bank miss");
    a_rx_stall_ans: assert property (s_tok_out ##0 (cfg_reg[tok.ep][`UEC_CFG_RXON]
        && !cfg_reg[tok.ep][`UEC_CFG_SILENT] && cfg_reg[tok.ep][`UEC_CFG_RX_STALL_REQUEST])
        |=> reply.hs == ($past(setup_reg[tok.ep]) ? UEC_HS_NAK : UEC_HS_STALL))
        else $error("rx stall answer wrong");
    a_setup_unstall: assert property (s_tok_setup ##0 setup_ok |=>
        !cfg_reg[$past(tok.ep)][`UEC_CFG_RX_STALL_REQUEST] && reply.store) else $error("setup kept stall");
    a_tx_stall_ans: assert property (s_tok_in ##0 (cfg_reg[tok.ep][`UEC_CFG_TXON]
        && !cfg_reg[tok.ep][`UEC_CFG_SILENT] && cfg_reg[tok.ep][`UEC_CFG_TX_STALL_REQUEST])
        |=> reply.hs == ($past(setup_reg[tok.ep]) ? UEC_HS_NAK : UEC_HS_STALL))
        else $error("tx stall");
    a_ctl_only: assert property (s_tok_setup ##0 !cfg_reg[tok.ep][`UEC_CFG_CTL]
        |=> reply.hs == UEC_HS_NONE && !reply.store) else $error("setup on non-control");
    a_silent_mode: assert property ((s_tok_in or s_tok_out)
        ##0 cfg_reg[tok.ep][`UEC_CFG_SILENT] |=> reply.hs == UEC_HS_NONE)
        else $error("silent endpoint answered");
    a_rx_gate_nak: assert property (s_tok_out ##0 (cfg_reg[tok.ep] & 8'h9C) == 8'h04
        |=> reply.hs == UEC_HS_NAK && !reply.store) else $error("closed gate");
    a_rx_off_quiet: assert property ((s_tok_out or s_tok_setup)
        ##0 !cfg_reg[tok.ep][`UEC_CFG_RXON] |=> reply.valid && reply.hs == UEC_HS_NONE)
        else $error("disabled rx answered");
    a_tx_off_quiet: assert property (s_tok_in ##0 !cfg_reg[tok.ep][`UEC_CFG_TXON]
        |=> reply.hs == UEC_HS_NONE) else $error("disabled tx answered");
endmodule
`default_nettype wire

// ### hw/uec_map.svh
/*
 Register map, bit positions and reset values of the endpoint control block.
 Assumes byte address = register index times four on a 32-bit bus.
*/
`ifndef UEC_MAP_SVH
`define UEC_MAP_SVH
// ============================================================
// register indices (byte address = index * 4)
`define UEC_IDX_WAKE     8'h03
`define UEC_IDX_SEL      8'h05
`define UEC_IDX_CFG      8'h06
`define UEC_IDX_TXRES    8'h0C
`define UEC_IDX_RXFLG    8'h0D
// ============================================================
// bit positions
`define UEC_WAKE_BIT     0
`define UEC_CFG_RX_STALL_REQUEST    7
`define UEC_CFG_TX_STALL_REQUEST    6
`define UEC_CFG_CTL      5
`define UEC_CFG_SILENT   4
`define UEC_CFG_RXGATE   3
`define UEC_CFG_RXON     2
`define UEC_CFG_TXALLOW  1
`define UEC_CFG_TXON     0
`define UEC_TXRES_SEQ    7
`define UEC_TXRES_VOID   2
`define UEC_TXRES_ERR    1
`define UEC_TXRES_ACK    0
`define UEC_RXFLG_SETUP  6
// ============================================================
// reset values and bus answers
`define UEC_CFG_RST_EP0  8'h25
`define UEC_CFG_RST_EPN  8'h00
`define UEC_BYTE_ZERO    8'h00
`define UEC_RESP_OKAY    2'h0
`define UEC_RESP_SLVERR  2'h2
`endif

// ### hw/uec_pkg.sv
/*
 Types shared by the endpoint control block: token, reply and transmit-end carriers.
 Assumes the serial engine runs on the same clock as this block.
*/
package uec_pkg;
    // token kinds from the serial engine; 2'h3 is illegal
    typedef enum logic [1:0] {
        UEC_PID_OUT   = 2'h0,
        UEC_PID_IN    = 2'h1,
        UEC_PID_SETUP = 2'h2
    } uec_pid_t;
    // answer chosen for a token
    typedef enum logic [2:0] {
        UEC_HS_NONE  = 3'h0,
        UEC_HS_ACK   = 3'h1,
        UEC_HS_NAK   = 3'h2,
        UEC_HS_STALL = 3'h3,
        UEC_HS_DATA  = 3'h4
    } uec_hs_t;
    typedef struct packed {
        logic       valid;
        uec_pid_t   pid;
        logic [1:0] ep;
    } uec_token_t;
    typedef struct packed {
        logic       valid;
        uec_hs_t    hs;
        logic       store;
        logic [1:0] ep;
    } uec_reply_t;
    typedef struct packed {
        logic       valid;
        logic       acked;
        logic [1:0] ep;
    } uec_txend_t;
endpackage

// ### bench/uec_host_model.sv
/*
 Host-side model: sends tokens and transmit-end pulses to the endpoint control.
 Assumes the serial engine shares sys_clk and reply comes one edge after a token.
*/
`timescale 1ns/10ps
`default_nettype none
module uec_host_model
    import uec_pkg::*;
(
    input  wire logic       sys_clk,
    output var  uec_token_t tok,
    output var  uec_txend_t tx_end,
    input  wire uec_reply_t reply
);
    // ============================================================
    // idle lines
    initial begin
        tok    = '0;
        tx_end = '0;
    end
    // one token pulse; released fields show the inverse so stale data never matches
    task automatic xfer(input uec_pid_t p, input logic [1:0] e, output uec_reply_t r);
        @(posedge sys_clk);
        tok <= '{1'b1, p, e};
        @(posedge sys_clk);
        tok <= '{1'b0, uec_pid_t'(~p), ~e};
        @(posedge sys_clk);
        r = reply; // answer stands one cycle only
    endtask
    // end of an IN data send, acked or not
    task automatic end_send(input logic a, input logic [1:0] e);
        @(posedge sys_clk);
        tx_end <= '{1'b1, a, e};
        @(posedge sys_clk);
        tx_end <= '{1'b0, ~a, ~e};
    endtask
endmodule
`default_nettype wire

// ### bench/uec_endpoint_control_tb.sv
/*
 Self-checking bench of the endpoint control: AXI4-Lite master tasks and tokens
 sent through the host model. Assumes one clock and the register map header.
*/
`timescale 1ns/10ps
`default_nettype none
`include "uec_map.svh"
module uec_endpoint_control_tb
    import uec_pkg::*;
;
    logic        sys_clk, rst;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, resume_drive;
    uec_token_t  tok;
    uec_txend_t  tx_end;
    uec_reply_t  reply;
    int          err_total, checked;
    uec_endpoint_control uec_endpoint_control_inst (.sys_clk, .rst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .tok, .tx_end, .reply, .resume_drive);
    uec_host_model uec_host_model_inst (.sys_clk, .tok, .tx_end, .reply);
    // ============================================================
    // compare and verdict
    task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_reply(input uec_hs_t h, input logic s, input logic [1:0] ep,
                             input uec_reply_t r);
        uec_reply_t e;
        e = '{1'b1, h, s, ep};
        checked++;
        if (r !== e) begin
            err_total++;
            $display("unexpected reply: expected %h seen %h", e, r);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ============================================================
    // bus master: holds each channel until its own ready, waits for the answer
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr  <= {2'h0, idx, 2'h0};
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= {24'h0, d}; // reserved bits always zero
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge sys_clk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        cmp_byte("write response", {6'h0, er}, {6'h0, s_axi_bresp});
    endtask
    task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] e,
                      input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr  <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        cmp_byte(nm, e, s_axi_rdata[7:0]);
        cmp_byte("read response", {6'h0, er}, {6'h0, s_axi_rresp});
    endtask
    // ============================================================
    // scenarios
    task automatic t_reset_and_index;
        rd("ep0 config", `UEC_IDX_CFG, `UEC_CFG_RST_EP0, `UEC_RESP_OKAY);
        for (int i = 1; i < 4; i++) begin
            wr(`UEC_IDX_SEL, 8'(i), `UEC_RESP_OKAY);
            rd("epN config", `UEC_IDX_CFG, `UEC_CFG_RST_EPN, `UEC_RESP_OKAY);
            wr(`UEC_IDX_CFG, 8'(8'h11 * i), `UEC_RESP_OKAY);
        end
        // each copy must come back distinct
        for (int i = 0; i < 4; i++) begin
            wr(`UEC_IDX_SEL, 8'(i), `UEC_RESP_OKAY);
            rd("select", `UEC_IDX_SEL, 8'(i), `UEC_RESP_OKAY);
            rd("config copy", `UEC_IDX_CFG, (i == 0) ? `UEC_CFG_RST_EP0 : 8'(8'h11 * i),
               `UEC_RESP_OKAY);
        end
        s_axi_wstrb <= 4'hE; // low lane masked: write must not land
        wr(`UEC_IDX_SEL, 8'h00, `UEC_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd("masked select", `UEC_IDX_SEL, 8'h03, `UEC_RESP_OKAY);
        rd("unmapped", 8'h3F, 8'h00, `UEC_RESP_SLVERR);
        wr(8'h3F, 8'hFF, `UEC_RESP_SLVERR);
        $display("test reset_and_index done");
    endtask
    task automatic t_wakeup;
        wr(`UEC_IDX_WAKE, 8'h01, `UEC_RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        cmp_byte("resume drive", 8'h01, {7'h0, resume_drive});
        wr(`UEC_IDX_WAKE, 8'h00, `UEC_RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        cmp_byte("resume drive", 8'h00, {7'h0, resume_drive});
        $display("test wakeup done");
    endtask
    task automatic t_decisions;
        // non-control ep1 with setup flag clear, then two control setups last
        logic [7:0] cf [14] = '{8'h00, 8'h04, 8'h0C, 8'h8C, 8'h88, 8'h1C, 8'h00,
                                8'h01, 8'h03, 8'h43, 8'h13, 8'h0C, 8'h28, 8'h2C};
        uec_pid_t pd [14] = '{UEC_PID_OUT, UEC_PID_OUT, UEC_PID_OUT, UEC_PID_OUT,
                              UEC_PID_OUT, UEC_PID_OUT, UEC_PID_IN, UEC_PID_IN, UEC_PID_IN,
                              UEC_PID_IN, UEC_PID_IN, UEC_PID_SETUP, UEC_PID_SETUP,
                              UEC_PID_SETUP};
        uec_hs_t hs [14] = '{UEC_HS_NONE, UEC_HS_NAK, UEC_HS_ACK, UEC_HS_STALL, UEC_HS_NONE,
                             UEC_HS_NONE, UEC_HS_NONE, UEC_HS_NAK, UEC_HS_DATA, UEC_HS_STALL,
                             UEC_HS_NONE, UEC_HS_NONE, UEC_HS_NONE, UEC_HS_ACK};
        logic [13:0] st = 14'h2004;
        uec_reply_t  r;
        wr(`UEC_IDX_SEL, 8'h01, `UEC_RESP_OKAY);
        for (int i = 0; i < 14; i++) begin
            wr(`UEC_IDX_CFG, cf[i], `UEC_RESP_OKAY);
            uec_host_model_inst.xfer(pd[i], 2'h1, r);
            cmp_reply(hs[i], st[i], 2'h1, r);
        end
        $display("test decisions done");
    endtask
    task automatic t_setup_on_ep0;
        uec_reply_t r;
        wr(`UEC_IDX_SEL, 8'h00, `UEC_RESP_OKAY);
        wr(`UEC_IDX_CFG, 8'hE4, `UEC_RESP_OKAY); // both stalls, gate closed
        uec_host_model_inst.xfer(UEC_PID_SETUP, 2'h0, r);
        cmp_reply(UEC_HS_ACK, 1'b1, 2'h0, r);
        rd("config after setup", `UEC_IDX_CFG, 8'h24, `UEC_RESP_OKAY);
        rd("setup flag", `UEC_IDX_RXFLG, 8'h40, `UEC_RESP_OKAY);
        wr(`UEC_IDX_CFG, 8'hE5, `UEC_RESP_OKAY);
        uec_host_model_inst.xfer(UEC_PID_OUT, 2'h0, r);
        cmp_reply(UEC_HS_NAK, 1'b0, 2'h0, r);
        uec_host_model_inst.xfer(UEC_PID_IN, 2'h0, r);
        cmp_reply(UEC_HS_NAK, 1'b0, 2'h0, r);
        wr(`UEC_IDX_RXFLG, 8'h00, `UEC_RESP_OKAY);
        uec_host_model_inst.xfer(UEC_PID_OUT, 2'h0, r);
        cmp_reply(UEC_HS_STALL, 1'b0, 2'h0, r);
        uec_host_model_inst.xfer(UEC_PID_IN, 2'h0, r);
        cmp_reply(UEC_HS_STALL, 1'b0, 2'h0, r);
        $display("test setup_on_ep0 done");
    endtask
    task automatic t_tx_result;
        uec_reply_t r;
        wr(`UEC_IDX_SEL, 8'h02, `UEC_RESP_OKAY);
        wr(`UEC_IDX_CFG, 8'h03, `UEC_RESP_OKAY);
        uec_host_model_inst.xfer(UEC_PID_IN, 2'h2, r);
        cmp_reply(UEC_HS_DATA, 1'b0, 2'h2, r);
        uec_host_model_inst.end_send(1'b1, 2'h2);
        rd("tx result", `UEC_IDX_TXRES, 8'h81, `UEC_RESP_OKAY);
        wr(`UEC_IDX_CFG, 8'h01, `UEC_RESP_OKAY);
        uec_host_model_inst.xfer(UEC_PID_IN, 2'h2, r);
        cmp_reply(UEC_HS_NAK, 1'b0, 2'h2, r);
        rd("tx result void", `UEC_IDX_TXRES, 8'h85, `UEC_RESP_OKAY);
        uec_host_model_inst.end_send(1'b0, 2'h2);
        rd("tx result error", `UEC_IDX_TXRES, 8'h86, `UEC_RESP_OKAY);
        wr(`UEC_IDX_TXRES, 8'h00, `UEC_RESP_OKAY);
        rd("tx result seq clear", `UEC_IDX_TXRES, 8'h06, `UEC_RESP_OKAY);
        $display("test tx_result done");
    endtask
    // ============================================================
    // clock, reset, sequence and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h10;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        err_total   = 0;
        checked     = 0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset_and_index;
        t_wakeup;
        t_decisions;
        t_setup_on_ep0;
        t_tx_result;
        print_verdict;
    end
    // a hang counts as a mismatch; the run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        print_verdict;
    end
endmodule
`default_nettype wire
